// ### rtl/sram_tap_pkg.sv
// package for the memory's boundary-scan test port
// assumes one system clock that oversamples the test clock pins
package sram_tap_pkg;

  // ****************************************
  // register sizes and counts
  // ****************************************
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W_DEF = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int TMS_RESET_EDGES = 5;

  // ****************************************
  // instruction codes and constants
  // ****************************************
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_IDCODE_DEF = 3'h1;
  localparam logic [2:0] OP_SAMPLE_Z_DEF = 3'h2;
  localparam logic [2:0] OP_SAMPLE_DEF = 3'h5;
  localparam logic [2:0] OP_BYPASS_DEF = 3'h7;
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
  localparam logic [2:0] IR_CAPTURE_WORD = {1'b0, IR_CAPTURE_LOW};
  // arbitrary identification word, not tied to any maker
  localparam logic [31:0] ID_WORD_DEF = 32'h0a5a_5001;

  // ****************************************
  // data register selection
  // ****************************************
  localparam logic [1:0] SEL_BYP = 2'h0;
  localparam logic [1:0] SEL_ID = 2'h1;
  localparam logic [1:0] SEL_BSR = 2'h2;

  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_e;

endpackage

// ### rtl/sram_tap.sv
// boundary-scan test port: snapshot fifo and the test access port itself
// assumes test clock, mode select and data in arrive unsynchronised from pins

// ****************************************
// snapshot fifo
// ****************************************
module snap_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // handshakes from the fill level
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  // storage, no reset needed on data
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // pointers and fill count
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// ****************************************
// test access port
// ****************************************
// opcode, length and id word parameters
module sram_tap #(
  parameter int BSR_W = sram_tap_pkg::BSR_W_DEF,
  parameter logic [2:0] OP_IDCODE = sram_tap_pkg::OP_IDCODE_DEF,
  parameter logic [2:0] OP_SAMPLE_Z = sram_tap_pkg::OP_SAMPLE_Z_DEF,
  parameter logic [2:0] OP_SAMPLE = sram_tap_pkg::OP_SAMPLE_DEF,
  parameter logic [2:0] OP_BYPASS = sram_tap_pkg::OP_BYPASS_DEF,
  parameter logic [31:0] ID_WORD = sram_tap_pkg::ID_WORD_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // test pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // pin snapshots from the memory core
  input wire logic snap_valid_i,
  output logic snap_ready_o,
  input wire logic [BSR_W-1:0] snap_data_i,
  // memory output control
  output logic mem_out_hiz_o
);
  sram_tap_pkg::tap_state_e state;
  logic tck_s1, tck_s2, tck_s3;
  logic tms_s1, tms_s2;
  logic tdi_s1, tdi_s2;
  logic rise, fall;
  logic [2:0] ir;
  logic [2:0] ir_sh;
  logic byp;
  logic [31:0] id_sh;
  logic [BSR_W-1:0] bsr;
  logic [1:0] sel;
  logic snap_valid;
  logic snap_pop;
  logic [BSR_W-1:0] snap_word;

  // next controller state from sampled mode select
  function automatic sram_tap_pkg::tap_state_e next_state(
    input sram_tap_pkg::tap_state_e st,
    input logic tms
  );
    case (st)
      sram_tap_pkg::ST_RESET:
        next_state = tms ? sram_tap_pkg::ST_RESET : sram_tap_pkg::ST_IDLE;
      sram_tap_pkg::ST_IDLE:
        next_state = tms ? sram_tap_pkg::ST_SEL_DR : sram_tap_pkg::ST_IDLE;
      sram_tap_pkg::ST_SEL_DR:
        next_state = tms ? sram_tap_pkg::ST_SEL_IR : sram_tap_pkg::ST_CAP_DR;
      sram_tap_pkg::ST_CAP_DR:
        next_state = tms ? sram_tap_pkg::ST_EXIT1_DR : sram_tap_pkg::ST_SHIFT_DR;
      sram_tap_pkg::ST_SHIFT_DR:
        next_state = tms ? sram_tap_pkg::ST_EXIT1_DR : sram_tap_pkg::ST_SHIFT_DR;
      sram_tap_pkg::ST_EXIT1_DR:
        next_state = tms ? sram_tap_pkg::ST_UPD_DR : sram_tap_pkg::ST_PAUSE_DR;
      sram_tap_pkg::ST_PAUSE_DR:
        next_state = tms ? sram_tap_pkg::ST_EXIT2_DR : sram_tap_pkg::ST_PAUSE_DR;
      sram_tap_pkg::ST_EXIT2_DR:
        next_state = tms ? sram_tap_pkg::ST_UPD_DR : sram_tap_pkg::ST_SHIFT_DR;
      sram_tap_pkg::ST_UPD_DR:
        next_state = tms ? sram_tap_pkg::ST_SEL_DR : sram_tap_pkg::ST_IDLE;
      sram_tap_pkg::ST_SEL_IR:
        next_state = tms ? sram_tap_pkg::ST_RESET : sram_tap_pkg::ST_CAP_IR;
      sram_tap_pkg::ST_CAP_IR:
        next_state = tms ? sram_tap_pkg::ST_EXIT1_IR : sram_tap_pkg::ST_SHIFT_IR;
      sram_tap_pkg::ST_SHIFT_IR:
        next_state = tms ? sram_tap_pkg::ST_EXIT1_IR : sram_tap_pkg::ST_SHIFT_IR;
      sram_tap_pkg::ST_EXIT1_IR:
        next_state = tms ? sram_tap_pkg::ST_UPD_IR : sram_tap_pkg::ST_PAUSE_IR;
      sram_tap_pkg::ST_PAUSE_IR:
        next_state = tms ? sram_tap_pkg::ST_EXIT2_IR : sram_tap_pkg::ST_PAUSE_IR;
      sram_tap_pkg::ST_EXIT2_IR:
        next_state = tms ? sram_tap_pkg::ST_UPD_IR : sram_tap_pkg::ST_SHIFT_IR;
      sram_tap_pkg::ST_UPD_IR:
        next_state = tms ? sram_tap_pkg::ST_SEL_DR : sram_tap_pkg::ST_IDLE;
      default:
        next_state = sram_tap_pkg::ST_RESET;
    endcase
  endfunction

  // ****************************************
  // pin synchronisers and edge finding
  // ****************************************
  // two stages before use; third tck stage only for edge finding
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
    end
    else
    begin
      tck_s1 <= tck_i;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= tms_i;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi_i;
      tdi_s2 <= tdi_s1;
    end
  end

  // edge enables
  // a test clock tied low gives no edges, so only the synchronisers and the snapshot fifo ever move
  assign rise = tck_s2 && !tck_s3;
  assign fall = !tck_s2 && tck_s3;

  // ****************************************
  // controller
  // ****************************************
  // sixteen-state machine
  // mode select taken on the rise only
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state <= sram_tap_pkg::ST_RESET;
    else if (rise)
      state <= next_state(state, tms_s2);
  end

  // instruction picks the data register
  // reserved codes fall back to bypass so the chain stays one bit long
  always_comb
  begin
    if (ir == OP_IDCODE)
      sel = sram_tap_pkg::SEL_ID;
    else if (ir == sram_tap_pkg::OP_EXTEST || ir == OP_SAMPLE_Z || ir == OP_SAMPLE)
      sel = sram_tap_pkg::SEL_BSR;
    else
      sel = sram_tap_pkg::SEL_BYP;
  end

  // ****************************************
  // instruction register
  // ****************************************
  // identification code at power-up and in reset state
  // shift only in the path, take effect at update
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ir <= OP_IDCODE;
      ir_sh <= OP_IDCODE;
    end
    else if (rise)
    begin
      case (state)
        sram_tap_pkg::ST_RESET:
          ir <= OP_IDCODE;
        sram_tap_pkg::ST_CAP_IR:
          ir_sh <= sram_tap_pkg::IR_CAPTURE_WORD;
        sram_tap_pkg::ST_SHIFT_IR:
          ir_sh <= {tdi_s2, ir_sh[2:1]};
        sram_tap_pkg::ST_UPD_IR:
          ir <= ir_sh;
        default:
          ir <= ir;
      endcase
    end
  end

  // ****************************************
  // data registers
  // ****************************************
  // bypass stage, cleared on capture
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      byp <= 1'b0;
    else if (rise && sel == sram_tap_pkg::SEL_BYP)
    begin
      if (state == sram_tap_pkg::ST_CAP_DR)
        byp <= 1'b0;
      else if (state == sram_tap_pkg::ST_SHIFT_DR)
        byp <= tdi_s2;
    end
  end

  // fixed identification word, data enters at the top
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      id_sh <= ID_WORD;
    else if (rise && sel == sram_tap_pkg::SEL_ID)
    begin
      if (state == sram_tap_pkg::ST_CAP_DR)
        id_sh <= ID_WORD;
      else if (state == sram_tap_pkg::ST_SHIFT_DR)
        id_sh <= {tdi_s2, id_sh[31:1]};
    end
  end

  // capture the oldest queued pin snapshot
  // an empty queue leaves the register as it stands rather than inventing a snapshot
  assign snap_pop = rise && sel == sram_tap_pkg::SEL_BSR
                    && state == sram_tap_pkg::ST_CAP_DR;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      bsr <= '0;
    else if (rise && sel == sram_tap_pkg::SEL_BSR)
    begin
      if (state == sram_tap_pkg::ST_CAP_DR && snap_valid)
        bsr <= snap_word;
      else if (state == sram_tap_pkg::ST_SHIFT_DR)
        bsr <= {tdi_s2, bsr[BSR_W-1:1]};
    end
  end

  // snapshot queue; a stalled capture side backs up into the core
  snap_fifo #(
    .WIDTH(BSR_W),
    .DEPTH(sram_tap_pkg::FIFO_DEPTH)
  ) u_snap_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(snap_valid_i),
    .in_ready_o(snap_ready_o),
    .in_data_i(snap_data_i),
    .out_valid_o(snap_valid),
    .out_ready_i(snap_pop),
    .out_data_o(snap_word)
  );

  // ****************************************
  // serial output and memory control
  // ****************************************
  // launch on fall, enable only while shifting
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (fall)
    begin
      tdo_oe_o <= (state == sram_tap_pkg::ST_SHIFT_IR)
                  || (state == sram_tap_pkg::ST_SHIFT_DR);
      if (state == sram_tap_pkg::ST_SHIFT_IR)
        tdo_o <= ir_sh[0];
      else if (sel == sram_tap_pkg::SEL_ID)
        tdo_o <= id_sh[0];
      else if (sel == sram_tap_pkg::SEL_BSR)
        tdo_o <= bsr[0];
      else
        tdo_o <= byp;
    end
  end

  // only these instructions reach the memory, via output float
  assign mem_out_hiz_o = (ir == sram_tap_pkg::OP_EXTEST) || (ir == OP_SAMPLE_Z);

  // ****************************************
  // checks
  // ****************************************
  logic [2:0] tms_run;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tms_run <= '0;
    else if (rise)
      tms_run <= !tms_s2 ? 3'h0 : (tms_run == 3'h7 ? tms_run : tms_run + 3'h1);
  end

  sequence s_rise_in(sram_tap_pkg::tap_state_e st);
    rise && state == st;
  endsequence

  property p_five_ones;
    @(posedge clk_i) disable iff (sys_rst_i)
    tms_run >= 3'(sram_tap_pkg::TMS_RESET_EDGES) |-> state == sram_tap_pkg::ST_RESET;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("five ones missed reset");

  property p_reset_ir;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_rise_in(sram_tap_pkg::ST_RESET) |=> ir == OP_IDCODE;
  endproperty
  a_reset_ir: assert property (p_reset_ir) else $error("reset lost id code");

  property p_cap_ir;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_rise_in(sram_tap_pkg::ST_CAP_IR) |=> ir_sh[1:0] == sram_tap_pkg::IR_CAPTURE_LOW;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture pattern wrong");

  property p_upd_ir;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_rise_in(sram_tap_pkg::ST_UPD_IR) |=> ir == $past(ir_sh);
  endproperty
  a_upd_ir: assert property (p_upd_ir) else $error("update did not load");

  property p_byp_clr;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_rise_in(sram_tap_pkg::ST_CAP_DR) ##0 sel == sram_tap_pkg::SEL_BYP |=> !byp;
  endproperty
  a_byp_clr: assert property (p_byp_clr) else $error("bypass not cleared");

  property p_id_cap;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_rise_in(sram_tap_pkg::ST_CAP_DR) ##0 sel == sram_tap_pkg::SEL_ID |=> id_sh == ID_WORD;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("id word not captured");

  property p_msb_in;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_rise_in(sram_tap_pkg::ST_SHIFT_DR) ##0 sel == sram_tap_pkg::SEL_BSR
      |=> bsr[BSR_W-1] == $past(tdi_s2);
  endproperty
  a_msb_in: assert property (p_msb_in) else $error("input not at msb");

  property p_lsb_out;
    @(posedge clk_i) disable iff (sys_rst_i)
    fall && state == sram_tap_pkg::ST_SHIFT_DR && sel == sram_tap_pkg::SEL_ID
      |=> tdo_o == $past(id_sh[0]) && tdo_oe_o;
  endproperty
  a_lsb_out: assert property (p_lsb_out) else $error("output not lsb");

  property p_oe_idle;
    @(posedge clk_i) disable iff (sys_rst_i)
    fall && state != sram_tap_pkg::ST_SHIFT_DR && state != sram_tap_pkg::ST_SHIFT_IR
      |=> !tdo_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("driver on outside shift");

  property p_pwr;
    @(posedge clk_i) sys_rst_i |=> !tdo_oe_o && state == sram_tap_pkg::ST_RESET;
  endproperty
  a_pwr: assert property (p_pwr) else $error("reset left driver on");

  property p_hiz;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_rise_in(sram_tap_pkg::ST_UPD_IR) ##0 ir_sh == sram_tap_pkg::OP_EXTEST |=> mem_out_hiz_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not floated");
endmodule

// ### tb/scan_master_model.sv
// behavioural scan master for the test pins
// assumes clk_i oversamples; tck is launched on clk edges
module scan_master_model (
  // bench clock
  input wire logic clk_i,
  // test pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  // recorded {oe, tdo}, one pulse per bit
  output logic bit_valid_o,
  output logic [1:0] bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // half period in clk cycles; 5 gives 40 ns, more is a slow master
  int half = 5;

  // clock parked low
  // data lines at pull-up level while idle
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    bit_valid_o = 1'b0;
    bit_o = 2'h0;
  end

  // one tck cycle
  // tms/tdi held past the fall so the device never sees a hold slip
  task automatic step(input logic tms, input logic tdi, input logic rec);
    @(posedge clk_i);
    tms_o <= tms;
    tdi_o <= tdi;
    // low for half cycles counting the edge above, high for half
    repeat (half - 1) @(posedge clk_i);
    tck_o <= 1'b1;
    bit_valid_o <= rec;
    bit_o <= {tdo_oe_i, tdo_i};
    @(posedge clk_i);
    bit_valid_o <= 1'b0;
    repeat (half - 1) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask

  task automatic tap_reset();
    repeat (sram_tap_pkg::TMS_RESET_EDGES) step(1'b1, 1'b1, 1'b0);
  endtask

  task automatic scan_ir(input logic [2:0] op);
    step(1'b1, 1'b1, 1'b0);
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++)
      step(i == 2, op[i], 1'b1);
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
  endtask

  task automatic scan_dr(input int n, input logic [31:0] din);
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], 1'b1);
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
  endtask
endmodule

// ### tb/tb_sram_boundary_scan_tap.sv
// bench for the memory's test port and its snapshot fifo
// assumes scan_master_model drives the pins; results compared from a queue
module tb_sram_boundary_scan_tap;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BW = 16;
  // arbitrary identification word
  localparam logic [31:0] ID = 32'h1234_abcd;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_pin;
  logic snap_valid = 1'b0;
  logic snap_ready;
  logic [BW-1:0] snap_data = '0;
  logic hiz;
  logic bit_valid;
  logic [1:0] bit_v;
  logic [1:0] exp_q[$];
  logic [BW-1:0] sq[$];
  int n_mismatch = 0;
  int checked = 0;
  int seed = 32'he6e5ad36;

  // ****************************************
  // clock, pins and instances
  // ****************************************
  always #4 clk = ~clk;
  // pin floats when not driven
  assign tdo_pin = tdo_oe ? tdo : 1'bz;

  sram_tap #(.BSR_W(BW), .ID_WORD(ID)) i_dut (
    .clk_i(clk), .sys_rst_i(sys_rst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .snap_valid_i(snap_valid),
    .snap_ready_o(snap_ready), .snap_data_i(snap_data), .mem_out_hiz_o(hiz)
  );

  scan_master_model i_ctrl (
    .clk_i(clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_pin),
    .tdo_oe_i(tdo_oe), .bit_valid_o(bit_valid), .bit_o(bit_v)
  );

  // ****************************************
  // checking
  // ****************************************
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  // each recorded bit against the oldest note
  always @(posedge clk)
  begin
    if (bit_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("tdo bit unexpected", 32'hffff_ffff, {30'h0, bit_v});
      else
        check("tdo bit", {30'h0, exp_q.pop_front()}, {30'h0, bit_v});
    end
  end

  task automatic tally_and_finish();
    if (exp_q.size() != 0)
    begin
      n_mismatch++;
      $display("[FAIL] notes left expected 0 seen %0d", exp_q.size());
    end
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // scan and fill helpers
  // ****************************************
  // note n bits, lsb first, driver enabled
  task automatic expect_bits(input int n, input logic [31:0] v);
    for (int i = 0; i < n; i++)
      exp_q.push_back({1'b1, v[i]});
  endtask

  task automatic load_ir(input logic [2:0] op);
    expect_bits(3, {29'h0, sram_tap_pkg::IR_CAPTURE_WORD});
    i_ctrl.scan_ir(op);
  endtask

  // bypass: one stage delay, first bit cleared
  task automatic read_dr(input int n, input logic [31:0] v, input logic byp);
    logic [31:0] din;
    din = $random(seed);
    expect_bits(n, byp ? {din[30:0], 1'b0} : v);
    i_ctrl.scan_dr(n, din);
  endtask

  // offer words until cnt taken; data only changes once accepted
  task automatic fill(input int cnt);
    int n;
    int guard;
    n = 0;
    guard = 0;
    @(posedge clk);
    snap_valid <= 1'b1;
    snap_data <= BW'($random(seed));
    while (n < cnt && guard < 200)
    begin
      @(negedge clk);
      guard++;
      if (snap_ready === 1'b1)
      begin
        sq.push_back(snap_data);
        n++;
        @(posedge clk);
        if (n == cnt)
          snap_valid <= 1'b0;
        else
          snap_data <= BW'($random(seed));
      end
    end
    check("words accepted", cnt, n);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    logic [2:0] op;
    logic bsr;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("oe after reset", 32'h0, {31'h0, tdo_oe});
    check("hiz after reset", 32'h0, {31'h0, hiz});
    i_ctrl.step(1'b0, 1'b1, 1'b0);
    read_dr(32, ID, 1'b0);
    check("oe in idle", 32'h0, {31'h0, tdo_oe});
    $display("test power-up id done");
    // slow master through bypass
    i_ctrl.half = 8;
    load_ir(sram_tap_pkg::OP_BYPASS_DEF);
    read_dr(24, 32'h0, 1'b1);
    i_ctrl.half = 5;
    $display("test bypass done");
    // every code, reserved ones act as bypass
    for (int k = 0; k < 8; k++)
    begin
      op = k[2:0];
      bsr = op == 3'h0 || op == sram_tap_pkg::OP_SAMPLE_Z_DEF;
      bsr = bsr || op == sram_tap_pkg::OP_SAMPLE_DEF;
      if (bsr)
        fill(1);
      load_ir(op);
      bsr = op == sram_tap_pkg::OP_EXTEST || op == sram_tap_pkg::OP_SAMPLE_Z_DEF;
      check("hiz", {31'h0, bsr}, {31'h0, hiz});
      bsr = bsr || op == sram_tap_pkg::OP_SAMPLE_DEF;
      if (bsr)
        read_dr(BW, 32'(sq.pop_front()), 1'b0);
      else if (op == sram_tap_pkg::OP_IDCODE_DEF)
        read_dr(32, ID, 1'b0);
      else
        read_dr(8, 32'h0, 1'b1);
    end
    $display("test opcodes done");
    fill(sram_tap_pkg::FIFO_DEPTH);
    @(negedge clk);
    check("ready when full", 32'h0, {31'h0, snap_ready});
    load_ir(sram_tap_pkg::OP_SAMPLE_DEF);
    repeat (sram_tap_pkg::FIFO_DEPTH) read_dr(BW, 32'(sq.pop_front()), 1'b0);
    @(negedge clk);
    check("ready when drained", 32'h1, {31'h0, snap_ready});
    $display("test snapshot fifo done");
    load_ir(3'h0);
    i_ctrl.tap_reset();
    check("hiz after tap reset", 32'h0, {31'h0, hiz});
    i_ctrl.step(1'b0, 1'b1, 1'b0);
    read_dr(32, ID, 1'b0);
    $display("test tap reset done");
    load_ir(sram_tap_pkg::OP_BYPASS_DEF);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("oe after second reset", 32'h0, {31'h0, tdo_oe});
    i_ctrl.step(1'b0, 1'b1, 1'b0);
    read_dr(32, ID, 1'b0);
    $display("test second reset done");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end

  // watchdog, about four times the expected run
  initial
  begin
    #400000;
    n_mismatch++;
    $display("[FAIL] watchdog expected finish seen timeout");
    tally_and_finish();
  end
endmodule
